// >>> core/cbr_pkg.sv
`default_nettype none
package cbr_pkg;
  // register port
  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned REG_DATA_W = 8;
  localparam logic [7:0] REG_VERSION = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h01;
  localparam logic [7:0] REG_CONFIG = 8'h02;
  localparam logic [7:0] REG_STATUS = 8'h03;
  // version value is arbitrary
  localparam logic [7:0] VERSION_VALUE = 8'h5a;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // general control: phy address high bits at 4..6
  localparam int unsigned PHY_HIGH_LSB = 4;
  localparam int unsigned PHY_HIGH_W = 3;
  localparam logic [2:0] PHY_HIGH_FIXED = 3'h0;
  // config fields
  localparam int unsigned CFG_SECOND_BOARD = 0;
  localparam int unsigned CFG_BOOT_SWAP = 1;
  localparam int unsigned CFG_EMULATOR_BOOT = 2;
  // status fields
  localparam int unsigned ST_SWITCH_LSB = 0;
  localparam int unsigned ST_WIDTH_LSB = 3;
  localparam int unsigned ST_PARITY_ERR = 5;
  localparam int unsigned ST_RESERVED_WIDTH = 6;
  localparam int unsigned ST_CLEAR_MASK_LSB = 5;
  // local bus
  localparam int unsigned LB_ADDR_W = 32;
  localparam int unsigned LB_DATA_W = 32;
  localparam int unsigned LB_LANES = 4;
  localparam int unsigned LANE_W = 8;
  localparam int unsigned ALIGNED_W = 24;
  localparam int unsigned ALIGN_BASE = 8;
  localparam int unsigned SELECTS = 8;
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam logic [1:0] WIDTH_RSVD = 2'h3;
  localparam int unsigned SHIFT_8 = 0;
  localparam int unsigned SHIFT_16 = 1;
  localparam int unsigned SHIFT_32 = 2;
  // select numbering
  localparam int unsigned CS_BOOT = 0;
  localparam int unsigned CS_ALT = 1;
  localparam int unsigned CS_SDRAM = 2;
  localparam int unsigned CS_NVRAM = 3;
  localparam int unsigned CS_HEADER = 4;
  // region of select 4, aligned address bits 23:22
  localparam logic [1:0] REGION_HEADER = 2'h0;
  localparam logic [1:0] REGION_FAST_ATM = 2'h1;
  localparam logic [1:0] REGION_SLOW_ATM = 2'h2;
  localparam logic [1:0] REGION_EXT_ATM = 2'h3;
  localparam int unsigned REGION_HI = 23;
  localparam int unsigned REGION_LO = 22;
  localparam logic ODD_PARITY = 1'b1;
  // communication ports, bit 0 is most significant
  localparam int unsigned PORT_W = 32;
  localparam int unsigned GROUPS = 3;
  // switched masks per port and group, index 0 leftmost
  localparam logic [0:31] PA_ONE = 32'hfc3f_ffff;
  localparam logic [0:31] PA_TWO = 32'h0000_0000;
  localparam logic [0:31] PA_THREE = 32'h0000_0000;
  localparam logic [0:31] PB_ONE = 32'h0000_0000;
  localparam logic [0:31] PB_TWO = 32'h0000_3ff7;
  localparam logic [0:31] PB_THREE = 32'h0ec0_c000;
  localparam logic [0:31] PC_ONE = 32'h0330_0c00;
  localparam logic [0:31] PC_TWO = 32'h3ccf_f000;
  localparam logic [0:31] PC_THREE = 32'h0000_0000;
  localparam logic [0:31] PD_ONE = 32'h0000_e000;
  localparam logic [0:31] PD_TWO = 32'h0670_0c02;
  localparam logic [0:31] PD_THREE = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> core/cbr_glue.sv
// Function
// - switch 0 routes a port group to its PHY, 1 to the expansion header
// - only designated bits are steered; others pass straight to the header
// - fourth ethernet port from port three runs 10/100 only, never gigabit
// - PHY management address is three high bits joined to port index
// - second board configuration ignores high bits; addresses stay fixed
// - each parity bit covers one data byte lane, bit 0 with lane 0
// - 32-bit bus address becomes a 24-bit size-aligned address by width
// - selects 0..4 reach boot flash, second flash, sdram, nvram, header
// - generate read and write strobes and per-device active-low selects
// - only the primary address latch strobe is used
// - alignment picks address bits 8..31, 7..30 or 6..29 by width
// - PHY high bits come from control register bits 4 to 6
//
// The implementer's own choices: the strobed register port and the register offsets.
`default_nettype none
module cbr_glue (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // local bus pins from the daughtercard
  input wire logic [0:31] local_bus_address,
  input wire logic [0:31] local_bus_data,
  input wire logic [0:3] local_bus_lane_parity,
  input wire logic [0:1] device_width_code,
  input wire logic [0:7] local_select_n,
  input wire logic local_output_enable_n,
  input wire logic [0:3] local_lane_write_n,
  input wire logic address_latch_strobe,
  // local bus outputs to the carrier
  output logic [23:0] aligned_local_address,
  output logic local_read_strobe_n,
  output logic local_write_strobe_n,
  output logic boot_bank_select_n,
  output logic alternate_bank_select_n,
  output logic boot_emulator_select_n,
  output logic nonvolatile_clock_select_n,
  output logic sdram_select_n,
  output logic header_select_n,
  output logic fast_atm_phy_select_n,
  output logic slow_atm_phy_select_n,
  output logic external_atm_phy_select_n,
  // communication ports and selector switches
  input wire logic [0:2] group_switch,
  input wire logic [0:31] cpu_port_a,
  input wire logic [0:31] cpu_port_b,
  input wire logic [0:31] cpu_port_c,
  input wire logic [0:31] cpu_port_d,
  output logic [0:31] phy_port_a,
  output logic [0:31] phy_port_b,
  output logic [0:31] phy_port_c,
  output logic [0:31] phy_port_d,
  output logic [0:31] header_port_a,
  output logic [0:31] header_port_b,
  output logic [0:31] header_port_c,
  output logic [0:31] header_port_d,
  output logic port_four_gigabit_enable,
  // phy management
  input wire logic [1:0] quad_port_index,
  output logic [4:0] phy_mgmt_address
);

  // pin synchronisers; the local bus, switch and cpu port pins are foreign to clk
  localparam int unsigned SYNC_W = 32 + 32 + 4 + 2 + 8 + 1 + 4 + 1 + 3 + 128;
  // idle pin levels, so no false select, strobe or parity error follows reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {70'h0, 8'hff, 1'b1, 4'hf, 132'h0};
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_pins;
  logic [0:31] s_addr;
  logic [0:31] s_data;
  logic [0:3] s_par;
  logic [0:1] s_width;
  logic [0:7] s_sel_n;
  logic s_oe_n;
  logic [0:3] s_we_n;
  logic s_ale;
  logic [0:2] s_sw;
  logic [0:31] s_pa;
  logic [0:31] s_pb;
  logic [0:31] s_pc;
  logic [0:31] s_pd;

  assign pin_raw = {local_bus_address, local_bus_data, local_bus_lane_parity,
                    device_width_code, local_select_n, local_output_enable_n,
                    local_lane_write_n, address_latch_strobe, group_switch,
                    cpu_port_a, cpu_port_b, cpu_port_c, cpu_port_d};
  assign {s_addr, s_data, s_par, s_width, s_sel_n, s_oe_n, s_we_n, s_ale, s_sw,
          s_pa, s_pb, s_pc, s_pd} = sync_pins;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_meta <= SYNC_IDLE;
      sync_pins <= SYNC_IDLE;
    end else begin
      sync_meta <= pin_raw;
      sync_pins <= sync_meta;
    end
  end

  // odd parity check of one byte lane
  function automatic logic lane_ok(input logic [7:0] lane, input logic par);
    lane_ok = ((^lane) ^ par) == cbr_pkg::ODD_PARITY;
  endfunction

  // steering of one port: pass bits always to header, switched bits by group
  function automatic logic [0:31] to_header(input logic [0:31] bits,
      input logic [0:31] m1, input logic [0:31] m2, input logic [0:31] m3,
      input logic [0:2] sw);
    logic [0:31] sel;
    sel = (sw[0] ? m1 : 32'h0000_0000) | (sw[1] ? m2 : 32'h0000_0000)
        | (sw[2] ? m3 : 32'h0000_0000);
    to_header = bits & (~(m1 | m2 | m3) | sel);
  endfunction

  function automatic logic [0:31] to_phy(input logic [0:31] bits,
      input logic [0:31] m1, input logic [0:31] m2, input logic [0:31] m3,
      input logic [0:2] sw);
    to_phy = bits & ((sw[0] ? 32'h0000_0000 : m1) | (sw[1] ? 32'h0000_0000 : m2)
           | (sw[2] ? 32'h0000_0000 : m3));
  endfunction

  // ---------------- registers ----------------
  logic [7:0] control;
  logic [7:0] config_reg;
  logic parity_err;
  logic rsvd_width_seen;
  logic [7:0] next_control;
  logic [7:0] next_config;
  logic next_parity_err;
  logic next_rsvd_width_seen;
  logic [7:0] next_reg_rdata;
  logic parity_event;
  logic rsvd_event;

  always_comb begin
    next_control = control;
    next_config = config_reg;
    next_reg_rdata = 8'h00;
    next_parity_err = parity_err;
    next_rsvd_width_seen = rsvd_width_seen;
    if (reg_write) begin
      if (reg_addr == cbr_pkg::REG_CONTROL) begin
        next_control = reg_wdata;
      end else if (reg_addr == cbr_pkg::REG_CONFIG) begin
        next_config = reg_wdata;
      end else if (reg_addr == cbr_pkg::REG_STATUS) begin
        // write one to clear
        if (reg_wdata[cbr_pkg::ST_PARITY_ERR]) begin
          next_parity_err = 1'b0;
        end
        if (reg_wdata[cbr_pkg::ST_RESERVED_WIDTH]) begin
          next_rsvd_width_seen = 1'b0;
        end
      end
    end
    // a new event beats a clear in the same cycle
    if (parity_event) begin
      next_parity_err = 1'b1;
    end
    if (rsvd_event) begin
      next_rsvd_width_seen = 1'b1;
    end
    if (reg_read) begin
      if (reg_addr == cbr_pkg::REG_VERSION) begin
        next_reg_rdata = cbr_pkg::VERSION_VALUE;
      end else if (reg_addr == cbr_pkg::REG_CONTROL) begin
        next_reg_rdata = control;
      end else if (reg_addr == cbr_pkg::REG_CONFIG) begin
        next_reg_rdata = config_reg;
      end else if (reg_addr == cbr_pkg::REG_STATUS) begin
        next_reg_rdata = {1'b0, rsvd_width_seen, parity_err, s_width, s_sw};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      control <= cbr_pkg::CONTROL_RESET;
      config_reg <= cbr_pkg::CONFIG_RESET;
      parity_err <= 1'b0;
      rsvd_width_seen <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      control <= next_control;
      config_reg <= next_config;
      parity_err <= next_parity_err;
      rsvd_width_seen <= next_rsvd_width_seen;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ---------------- local bus ----------------
  logic ale_q;
  logic [0:31] latched_addr;
  logic [0:31] next_latched_addr;
  logic [23:0] next_aligned;
  logic [0:3] lane_good;
  logic write_any;
  logic any_select;
  logic [1:0] region;

  // address is taken on the primary strobe's rising edge only
  always_comb begin
    next_latched_addr = latched_addr;
    if (s_ale && !ale_q) begin
      next_latched_addr = s_addr;
    end
  end

  always_comb begin
    // reserved code keeps the 8-bit mapping
    next_aligned = latched_addr[cbr_pkg::ALIGN_BASE +: 24];
    case (s_width)
      cbr_pkg::WIDTH_16: next_aligned = latched_addr[cbr_pkg::ALIGN_BASE - 1 +: 24];
      cbr_pkg::WIDTH_32: next_aligned = latched_addr[cbr_pkg::ALIGN_BASE - 2 +: 24];
      default: next_aligned = latched_addr[cbr_pkg::ALIGN_BASE +: 24];
    endcase
  end

  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_good[g] = lane_ok(s_data[g*8 +: 8], s_par[g]);
  end

  assign write_any = ~&s_we_n;
  assign any_select = ~&s_sel_n[cbr_pkg::CS_BOOT:cbr_pkg::CS_HEADER];
  assign parity_event = write_any && any_select && !(&lane_good);
  // only code 11 can be seen here; the other party must not drive it
  assign rsvd_event = (s_width == cbr_pkg::WIDTH_RSVD) && any_select;
  assign region = next_aligned[cbr_pkg::REGION_HI:cbr_pkg::REGION_LO];

  logic next_rd_n;
  logic next_wr_n;
  logic next_boot_n;
  logic next_alt_n;
  logic next_emu_n;
  logic next_nv_n;
  logic next_sdram_n;
  logic next_hdr_n;
  logic next_fast_n;
  logic next_slow_n;
  logic next_ext_n;
  logic boot_sel;
  logic alt_sel;

  always_comb begin
    // swap lets the alternate bank boot without rewiring selects 0 and 1
    boot_sel = config_reg[cbr_pkg::CFG_BOOT_SWAP] ? !s_sel_n[cbr_pkg::CS_ALT]
                                                  : !s_sel_n[cbr_pkg::CS_BOOT];
    alt_sel = config_reg[cbr_pkg::CFG_BOOT_SWAP] ? !s_sel_n[cbr_pkg::CS_BOOT]
                                                 : !s_sel_n[cbr_pkg::CS_ALT];
    next_emu_n = !(boot_sel && config_reg[cbr_pkg::CFG_EMULATOR_BOOT]);
    next_boot_n = !(boot_sel && !config_reg[cbr_pkg::CFG_EMULATOR_BOOT]);
    next_alt_n = !alt_sel;
    next_sdram_n = s_sel_n[cbr_pkg::CS_SDRAM];
    next_nv_n = s_sel_n[cbr_pkg::CS_NVRAM];
    next_hdr_n = !(!s_sel_n[cbr_pkg::CS_HEADER] && region == cbr_pkg::REGION_HEADER);
    next_fast_n = !(!s_sel_n[cbr_pkg::CS_HEADER] && region == cbr_pkg::REGION_FAST_ATM);
    next_slow_n = !(!s_sel_n[cbr_pkg::CS_HEADER] && region == cbr_pkg::REGION_SLOW_ATM);
    next_ext_n = !(!s_sel_n[cbr_pkg::CS_HEADER] && region == cbr_pkg::REGION_EXT_ATM);
    // selects 5..7 stay reserved and reach nothing
    next_rd_n = !(!s_oe_n && any_select);
    next_wr_n = !(write_any && any_select);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ale_q <= 1'b0;
      latched_addr <= '0;
      aligned_local_address <= '0;
      local_read_strobe_n <= 1'b1;
      local_write_strobe_n <= 1'b1;
      boot_bank_select_n <= 1'b1;
      alternate_bank_select_n <= 1'b1;
      boot_emulator_select_n <= 1'b1;
      nonvolatile_clock_select_n <= 1'b1;
      sdram_select_n <= 1'b1;
      header_select_n <= 1'b1;
      fast_atm_phy_select_n <= 1'b1;
      slow_atm_phy_select_n <= 1'b1;
      external_atm_phy_select_n <= 1'b1;
    end else begin
      ale_q <= s_ale;
      latched_addr <= next_latched_addr;
      aligned_local_address <= next_aligned;
      local_read_strobe_n <= next_rd_n;
      local_write_strobe_n <= next_wr_n;
      boot_bank_select_n <= next_boot_n;
      alternate_bank_select_n <= next_alt_n;
      boot_emulator_select_n <= next_emu_n;
      nonvolatile_clock_select_n <= next_nv_n;
      sdram_select_n <= next_sdram_n;
      header_select_n <= next_hdr_n;
      fast_atm_phy_select_n <= next_fast_n;
      slow_atm_phy_select_n <= next_slow_n;
      external_atm_phy_select_n <= next_ext_n;
    end
  end

  // ---------------- port steering and phy address ----------------
  logic [0:31] next_phy_a;
  logic [0:31] next_phy_b;
  logic [0:31] next_phy_c;
  logic [0:31] next_phy_d;
  logic [0:31] next_hdr_a;
  logic [0:31] next_hdr_b;
  logic [0:31] next_hdr_c;
  logic [0:31] next_hdr_d;
  logic [2:0] phy_high;
  logic [4:0] next_phy_mgmt;

  always_comb begin
    next_phy_a = to_phy(s_pa, cbr_pkg::PA_ONE, cbr_pkg::PA_TWO, cbr_pkg::PA_THREE, s_sw);
    next_phy_b = to_phy(s_pb, cbr_pkg::PB_ONE, cbr_pkg::PB_TWO, cbr_pkg::PB_THREE, s_sw);
    next_phy_c = to_phy(s_pc, cbr_pkg::PC_ONE, cbr_pkg::PC_TWO, cbr_pkg::PC_THREE, s_sw);
    next_phy_d = to_phy(s_pd, cbr_pkg::PD_ONE, cbr_pkg::PD_TWO, cbr_pkg::PD_THREE, s_sw);
    next_hdr_a = to_header(s_pa, cbr_pkg::PA_ONE, cbr_pkg::PA_TWO, cbr_pkg::PA_THREE, s_sw);
    next_hdr_b = to_header(s_pb, cbr_pkg::PB_ONE, cbr_pkg::PB_TWO, cbr_pkg::PB_THREE, s_sw);
    next_hdr_c = to_header(s_pc, cbr_pkg::PC_ONE, cbr_pkg::PC_TWO, cbr_pkg::PC_THREE, s_sw);
    next_hdr_d = to_header(s_pd, cbr_pkg::PD_ONE, cbr_pkg::PD_TWO, cbr_pkg::PD_THREE, s_sw);
    phy_high = config_reg[cbr_pkg::CFG_SECOND_BOARD] ? cbr_pkg::PHY_HIGH_FIXED
             : control[cbr_pkg::PHY_HIGH_LSB +: cbr_pkg::PHY_HIGH_W];
    next_phy_mgmt = {phy_high, quad_port_index};
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phy_port_a <= '0;
      phy_port_b <= '0;
      phy_port_c <= '0;
      phy_port_d <= '0;
      header_port_a <= '0;
      header_port_b <= '0;
      header_port_c <= '0;
      header_port_d <= '0;
      port_four_gigabit_enable <= 1'b0;
      phy_mgmt_address <= 5'h00;
    end else begin
      phy_port_a <= next_phy_a;
      phy_port_b <= next_phy_b;
      phy_port_c <= next_phy_c;
      phy_port_d <= next_phy_d;
      header_port_a <= next_hdr_a;
      header_port_b <= next_hdr_b;
      header_port_c <= next_hdr_c;
      header_port_d <= next_hdr_d;
      // the port-three pins carry only an mii-class link
      port_four_gigabit_enable <= 1'b0;
      phy_mgmt_address <= next_phy_mgmt;
    end
  end

endmodule
`default_nettype wire

// >>> dv/cbr_glue_properties.sv
`default_nettype none
module cbr_glue_properties (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  // pins
  input wire logic [0:2] group_switch,
  input wire logic [0:31] cpu_port_a,
  input wire logic [0:7] local_select_n,
  input wire logic local_output_enable_n,
  input wire logic [0:3] local_lane_write_n,
  input wire logic [1:0] quad_port_index,
  // outputs
  input wire logic [0:31] phy_port_a,
  input wire logic [0:31] header_port_a,
  input wire logic local_read_strobe_n,
  input wire logic local_write_strobe_n,
  input wire logic boot_bank_select_n,
  input wire logic nonvolatile_clock_select_n,
  input wire logic header_select_n,
  input wire logic port_four_gigabit_enable,
  input wire logic [4:0] phy_mgmt_address
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up;
  logic second;
  logic settled;
  assign settled = (up == 3'h7);
  // age counter so that $past never looks back into reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      up <= 3'h0;
      second <= 1'b0;
    end else begin
      if (!settled) up <= up + 3'h1;
      if (reg_write && reg_addr == cbr_pkg::REG_CONFIG) second <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_ctrl_write;
    reg_write && reg_addr == cbr_pkg::REG_CONTROL && !second;
  endsequence
  sequence s_quiet;
    !reg_write [*2];
  endsequence
  AST_CTRL_HIGH: assert property ( // control high bits
    s_ctrl_write ##1 s_quiet |-> phy_mgmt_address[4:2] == $past(reg_wdata[6:4], 2))
    else $error("phy high bits do not follow control write");
  AST_SECOND_FIXED: assert property ( // fixed high bits
    second [*3] |-> phy_mgmt_address[4:2] == cbr_pkg::PHY_HIGH_FIXED)
    else $error("phy high bits not fixed in second board mode");
  AST_PORT_INDEX: assert property ( // low bits
    settled |-> phy_mgmt_address[1:0] == $past(quad_port_index))
    else $error("phy low bits differ from port index");
  AST_GROUP_ONE: assert property ( // steering
    settled |-> (phy_port_a & cbr_pkg::PA_ONE) ==
    ($past(group_switch[0], 3) ? 32'h0 : $past(cpu_port_a, 3) & cbr_pkg::PA_ONE))
    else $error("group one steering wrong");
  AST_PASS_THROUGH: assert property ( // pass bits
    settled |-> header_port_a[6:9] == $past(cpu_port_a[6:9], 3))
    else $error("pass-through bits wrong");
  AST_NO_GIGABIT: assert property ( // fourth port
    port_four_gigabit_enable == 1'b0)
    else $error("fourth port gigabit enabled");
  AST_NVRAM_SEL: assert property ( // select three
    settled |-> nonvolatile_clock_select_n == $past(local_select_n[3], 3))
    else $error("clock select does not follow select three");
  AST_RESERVED_SEL: assert property ( // no device
    settled && $past(local_select_n[0:4], 3) == 5'h1f |->
    {boot_bank_select_n, header_select_n, nonvolatile_clock_select_n} == 3'h7)
    else $error("device selected without select 0 to 4");
  AST_READ_STROBE: assert property ( // read strobe
    settled |-> local_read_strobe_n ==
    !(!$past(local_output_enable_n, 3) && $past(local_select_n[0:4], 3) != 5'h1f))
    else $error("read strobe wrong");
  AST_WRITE_STROBE: assert property ( // write strobe
    settled |-> local_write_strobe_n ==
    !($past(local_lane_write_n, 3) != 4'hf && $past(local_select_n[0:4], 3) != 5'h1f))
    else $error("write strobe wrong");
endmodule
bind cbr_glue cbr_glue_properties u_props (.*);
`default_nettype wire

// >>> dv/cbr_card_model.sv
`default_nettype none
module cbr_card_model (
  // clock
  input wire logic clk,
  // local bus towards the carrier
  output logic [0:31] local_bus_address,
  output logic [0:31] local_bus_data,
  output logic [0:3] local_bus_lane_parity,
  output logic [0:1] device_width_code,
  output logic [0:7] local_select_n,
  output logic local_output_enable_n,
  output logic [0:3] local_lane_write_n,
  output logic address_latch_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic driving = 1'b0;
  initial begin
    local_bus_address = 32'h0;
    local_bus_data = 32'h0;
    local_bus_lane_parity = 4'h0;
    device_width_code = 2'h0;
    local_select_n = 8'hff;
    local_output_enable_n = 1'b1;
    local_lane_write_n = 4'hf;
    address_latch_strobe = 1'b0;
  end
  // released lines keep moving, so a stale value cannot pass for a live one
  always @(posedge clk) begin
    if (!driving) begin
      local_bus_data <= ~local_bus_data;
      local_bus_lane_parity <= ~local_bus_lane_parity;
    end
  end
  task automatic cycle(input logic [0:31] a, input logic [0:31] d, input logic [0:1] w,
    input int sel, input logic wr, input logic [0:3] bad);
    // claimed before the edge, so the idle toggling never meets the drive
    driving = 1'b1;
    @(posedge clk);
    local_bus_address <= a;
    local_bus_data <= d;
    device_width_code <= w; // reserved code only when asked
    for (int g = 0; g < 4; g++) begin
      local_bus_lane_parity[g] <= ^d[8 * g +: 8] ^ cbr_pkg::ODD_PARITY ^ bad[g];
    end
    local_select_n <= ~(8'h80 >> sel);
    local_output_enable_n <= wr;
    local_lane_write_n <= wr ? 4'h0 : 4'hf;
    @(posedge clk);
    address_latch_strobe <= 1'b1; // only the primary latch line
    @(posedge clk);
    address_latch_strobe <= 1'b0;
    repeat (5) @(posedge clk);
    local_select_n <= 8'hff;
    local_output_enable_n <= 1'b1;
    local_lane_write_n <= 4'hf;
    driving = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/cbr_glue_tb.sv
`default_nettype none
module cbr_glue_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int due; int id; logic [31:0] val;} cbr_note_s;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_write = 1'b0, reg_read = 1'b0;
  logic [0:31] local_bus_address, local_bus_data;
  logic [0:3] local_bus_lane_parity, local_lane_write_n;
  logic [0:1] device_width_code;
  logic [0:7] local_select_n;
  logic local_output_enable_n, address_latch_strobe, port_four_gigabit_enable;
  logic [23:0] aligned_local_address;
  logic local_read_strobe_n, local_write_strobe_n, boot_bank_select_n, alternate_bank_select_n;
  logic boot_emulator_select_n, nonvolatile_clock_select_n, sdram_select_n, header_select_n;
  logic fast_atm_phy_select_n, slow_atm_phy_select_n, external_atm_phy_select_n;
  logic [0:2] group_switch = 3'h0;
  logic [0:31] cpu_port_a = 32'h0, cpu_port_b = 32'h0, cpu_port_c = 32'h0, cpu_port_d = 32'h0;
  logic [0:31] phy_port_a, phy_port_b, phy_port_c, phy_port_d;
  logic [0:31] header_port_a, header_port_b, header_port_c, header_port_d;
  logic [1:0] quad_port_index = 2'h0;
  logic [4:0] phy_mgmt_address;
  logic [31:0] rng = 32'h30;
  logic [0:31] pv [4];
  logic [0:31] a;
  logic [31:0] got;
  cbr_note_s notes[$];
  cbr_note_s n;
  int failures = 0;
  int check_count = 0;
  int ncyc = 0;
  int s;
  cbr_glue u_dut (.*);
  cbr_card_model u_card (.*);
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // due counts negedges; every drive lands on the next rising edge
  function automatic void note(input int id, input logic [31:0] v, input int lat);
    notes.push_back('{ncyc + lat + 2, id, v});
  endfunction
  function automatic logic [0:31] mk(input int p, input logic [0:2] sw);
    logic [0:31] t [12];
    logic [0:31] m;
    t = '{cbr_pkg::PA_ONE, cbr_pkg::PA_TWO, cbr_pkg::PA_THREE, cbr_pkg::PB_ONE,
      cbr_pkg::PB_TWO, cbr_pkg::PB_THREE, cbr_pkg::PC_ONE, cbr_pkg::PC_TWO,
      cbr_pkg::PC_THREE, cbr_pkg::PD_ONE, cbr_pkg::PD_TWO, cbr_pkg::PD_THREE};
    m = 32'h0;
    for (int g = 0; g < 3; g++) if (!sw[g]) m = m | t[3 * p + g];
    return m;
  endfunction
  function automatic logic [31:0] sel_exp(input int sel, input logic wr, input logic [1:0] r);
    logic [10:0] v;
    v = 11'h7ff;
    if (sel < 5) v[wr ? 9 : 10] = 1'b0;
    case (sel)
      0: v[8] = 1'b0;
      1: v[7] = 1'b0;
      2: v[4] = 1'b0;
      3: v[5] = 1'b0;
      4: v[3 - r] = 1'b0;
      default: v = v;
    endcase
    return {21'h0, v};
  endfunction
  function automatic logic [31:0] obs(input int id);
    case (id)
      0: return {24'h0, reg_rdata};
      1: return {8'h0, aligned_local_address};
      2: return {21'h0, local_read_strobe_n, local_write_strobe_n, boot_bank_select_n,
        alternate_bank_select_n, boot_emulator_select_n, nonvolatile_clock_select_n,
        sdram_select_n, header_select_n, fast_atm_phy_select_n, slow_atm_phy_select_n,
        external_atm_phy_select_n};
      3: return phy_port_a;
      4: return phy_port_b;
      5: return phy_port_c;
      6: return phy_port_d;
      7: return header_port_a;
      8: return header_port_b;
      9: return header_port_c;
      10: return header_port_d;
      default: return {27'h0, phy_mgmt_address};
    endcase
  endfunction
  task automatic conclude();
    failures = failures + notes.size();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    note(0, {24'h0, e}, 1);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_read <= 1'b0;
  endtask
  always @(negedge clk) begin
    ncyc = ncyc + 1;
    if (ncyc > 2000) begin
      failures = failures + 1;
      conclude();
    end
    while (notes.size() > 0 && notes[0].due == ncyc) begin
      n = notes.pop_front();
      got = obs(n.id);
      check_count = check_count + 1;
      if (got !== n.val) begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, n.val);
      end
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(cbr_pkg::REG_VERSION, cbr_pkg::VERSION_VALUE);
    rd(cbr_pkg::REG_CONTROL, cbr_pkg::CONTROL_RESET);
    rd(cbr_pkg::REG_CONFIG, cbr_pkg::CONFIG_RESET);
    rd(8'h3c, 8'h00);
    for (int h = 0; h < 8; h++) begin
      a = rnd();
      quad_port_index <= a[30:31];
      note(11, {27'h0, 3'(h), a[30:31]}, 2);
      wr(cbr_pkg::REG_CONTROL, {1'b0, 3'(h), 4'h0});
      rd(cbr_pkg::REG_CONTROL, {1'b0, 3'(h), 4'h0});
    end
    wr(cbr_pkg::REG_CONFIG, 8'h01);
    note(11, {27'h0, cbr_pkg::PHY_HIGH_FIXED, a[30:31]}, 2);
    wr(cbr_pkg::REG_CONTROL, 8'h50);
    wr(cbr_pkg::REG_CONFIG, 8'h00);
    for (int w = 0; w < 4; w++) begin
      a = rnd();
      s = (w == 1) ? 7 : (w == 2) ? 6 : 8;
      note(2, sel_exp(3, 1'b0, 2'h0), 3);
      note(1, {8'h0, a[s +: 24]}, 5);
      u_card.cycle(a, rnd(), 2'(w), 3, 1'b0, 4'h0);
    end
    for (int k = 0; k < 11; k++) begin
      a = {8'h0, (k < 8) ? 2'h0 : 2'(k - 7), 22'h0};
      u_card.cycle(a, rnd(), 2'h0, 8, 1'b0, 4'h0);
      note(2, sel_exp((k < 8) ? k : 4, k[0], a[8:9]), 3);
      u_card.cycle(a, rnd(), 2'h0, (k < 8) ? k : 4, k[0], 4'h0);
    end
    for (int c = 1; c < 3; c++) begin
      wr(cbr_pkg::REG_CONFIG, 8'(2 * c));
      note(2, sel_exp(0, 1'b0, 2'h0) ^ ((c == 1) ? 32'h180 : 32'h140), 3);
      u_card.cycle(32'h0, rnd(), 2'h0, 0, 1'b0, 4'h0);
    end
    wr(cbr_pkg::REG_CONFIG, 8'h00);
    rd(cbr_pkg::REG_STATUS, 8'h40);
    u_card.cycle(32'h0, rnd(), 2'h0, 2, 1'b1, 4'h1);
    rd(cbr_pkg::REG_STATUS, 8'h60);
    wr(cbr_pkg::REG_STATUS, 8'h60);
    rd(cbr_pkg::REG_STATUS, 8'h00);
    for (int sw = 0; sw < 8; sw++) begin
      for (int p = 0; p < 4; p++) begin
        pv[p] = rnd();
        note(3 + p, pv[p] & mk(p, 3'(sw)), 3);
      end
      for (int p = 0; p < 4; p++) note(7 + p, pv[p] & ~mk(p, 3'(sw)), 3);
      @(posedge clk);
      group_switch <= 3'(sw);
      cpu_port_a <= pv[0];
      cpu_port_b <= pv[1];
      cpu_port_c <= pv[2];
      cpu_port_d <= pv[3];
    end
    repeat (6) @(posedge clk);
    conclude();
  end
endmodule
`default_nettype wire
